// >>> rtl/uac_pkg.sv
package uac_pkg;

    // ------------------------------------------------------------
    // Operating modes
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        UAC_MODE_MUL,
        UAC_MODE_ADDSUB,
        UAC_MODE_MUL_ADD,
        UAC_MODE_ADD_MUL
    } uac_mode_t;

    // ------------------------------------------------------------
    // Widths and constants
    // ------------------------------------------------------------
    localparam int          UAC_DATA_W    = 16;
    localparam int          UAC_PROD_W    = 32;
    localparam int          UAC_SHIFT_W   = 5;
    localparam logic [15:0] UAC_SAT_MAX   = 16'hFFFF;
    localparam logic [15:0] UAC_UNDERFLOW = 16'h0000;
    localparam logic [15:0] UAC_RESULT_RST = 16'h0000;
    localparam int          UAC_LATENCY   = 1;

endpackage : uac_pkg

// >>> rtl/uac_arith_core.sv
`timescale 1ns/10ps
// Overview of operation
// RULE1: Four modes: multiply, add/subtract, multiply then add/sub, add/sub then multiply.
// RULE2: Multiply mode: 16x16 product to 32 bits, shifted down to 16 bits.
// RULE3: Add/subtract mode outputs sum or difference of the two addends.
// RULE4: Multiply-then-add routes shifted product into first addend automatically.
// RULE5: Add-then-multiply feeds sum or difference into multiplicand, times scale.
// RULE6: Any stage result above the 16-bit maximum saturates to all ones; a saturated product minus B gives all ones minus B.
// RULE7: Operands unsigned; a negative difference outputs zero.
// RULE8: Right-shift setting N divides by two to the power N.
// RULE9: Result registered on the next clock edge; clears to zero on reset.
module uac_arith_core
    import uac_pkg::*;
#(
    parameter int DATA_W  = UAC_DATA_W,
    parameter int SHIFT_W = UAC_SHIFT_W
) (
    input  wire logic               core_clk,   // System clock
    input  wire logic               rst,        // Synchronous reset, active high
    input  wire uac_mode_t          mode,       // Operating mode
    input  wire logic               sub_sel,    // 1 selects subtract, 0 add
    input  wire logic [SHIFT_W-1:0] shift_amt,  // Right shift of the product
    input  wire logic [DATA_W-1:0]  scale_k,    // Scale operand
    input  wire logic [DATA_W-1:0]  mcand_x,    // Multiplicand operand
    input  wire logic [DATA_W-1:0]  addend_a,   // First addend
    input  wire logic [DATA_W-1:0]  addend_b,   // Second addend
    output logic      [DATA_W-1:0]  result      // Registered result
);

    // ------------------------------------------------------------
    // Shared constants and stage nets
    // ------------------------------------------------------------
    localparam logic [DATA_W-1:0] MAXV = {DATA_W{1'b1}};
    // Floor for a subtraction that would borrow
    localparam logic [DATA_W-1:0] ZERO = DATA_W'(UAC_UNDERFLOW);

    logic [DATA_W-1:0]   result_r;
    logic [DATA_W-1:0]   result_nxt;
    logic [DATA_W-1:0]   mul_x;
    logic [DATA_W-1:0]   add_a;
    logic [2*DATA_W-1:0] prod;
    logic [2*DATA_W-1:0] prod_sh;
    logic [DATA_W-1:0]   f_out;
    logic [DATA_W-1:0]   y_out;

    // ------------------------------------------------------------
    // Adder / subtractor
    // ------------------------------------------------------------
    // One extra carry bit tells an overflowing sum from a legal one; the
    // core has no negative values, so a subtraction that would borrow is
    // pinned at zero instead of wrapping round.
    function automatic logic [DATA_W-1:0] addsub(input logic [DATA_W-1:0] a,
                                                 input logic [DATA_W-1:0] b,
                                                 input logic              sub);
        logic [DATA_W:0] s;
        s = '0;
        if (sub) begin
            if (a < b) begin
                s = {1'b0, ZERO};                               // [RULE7]
            end else begin
                s = {1'b0, a} - {1'b0, b};                      // [RULE3]
            end
        end else begin
            s = {1'b0, a} + {1'b0, b};                          // [RULE3]
        end
        return s[DATA_W] ? MAXV : s[DATA_W-1:0];                // [RULE6]
    endfunction : addsub

    // First-stage adder always works on the external addends
    always_comb begin
        y_out = addsub(addend_a, addend_b, sub_sel);            // [RULE3]
    end

    // ------------------------------------------------------------
    // Multiplier / shifter
    // ------------------------------------------------------------
    // The full double-width product is kept until after the shift, so a large
    // product that the shift brings back into range is not lost. Whatever
    // still sits above the data width after the shift saturates the stage.
    always_comb begin
        // Adder output steers the multiplicand only in add-then-multiply mode
        mul_x   = (mode == UAC_MODE_ADD_MUL) ? y_out : mcand_x; // [RULE5]
        prod    = mul_x * scale_k;                              // [RULE2]
        prod_sh = prod >> shift_amt;                            // [RULE8]
        f_out   = (|prod_sh[2*DATA_W-1:DATA_W]) ? MAXV
                                                : prod_sh[DATA_W-1:0]; // [RULE6]
    end

    // ------------------------------------------------------------
    // Second stage and mode select
    // ------------------------------------------------------------
    // In multiply-then-add mode the product is saturated before it reaches
    // the adder, so a huge product minus B gives all ones minus B.
    always_comb begin
        add_a = (mode == UAC_MODE_MUL_ADD) ? f_out : addend_a;  // [RULE4]
        case (mode)                                             // [RULE1]
            UAC_MODE_MUL:     result_nxt = f_out;               // [RULE2]
            UAC_MODE_ADDSUB:  result_nxt = y_out;               // [RULE3]
            UAC_MODE_MUL_ADD: result_nxt = addsub(add_a, addend_b, sub_sel); // [RULE4]
            UAC_MODE_ADD_MUL: result_nxt = f_out;               // [RULE5]
            default:          result_nxt = DATA_W'(UAC_RESULT_RST);
        endcase
    end

    // ------------------------------------------------------------
    // Result register
    // ------------------------------------------------------------
    // The result is the only state in the core; it is reloaded on every
    // edge, so a changed operand shows one cycle later and never earlier.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            result_r <= DATA_W'(UAC_RESULT_RST);                // [RULE9]
        end else begin
            result_r <= result_nxt;                             // [RULE9]
        end
    end

    assign result = result_r;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    // Expected values are rebuilt from the operands at full width, so a
    // truncated product cannot hide behind the same truncation.
    a_reset_clears: assert property (@(posedge core_clk) // [RULE9]
        rst |=> result == '0)
        else $error("result not zero after reset");

    a_add_result: assert property (@(posedge core_clk) disable iff (rst) // [RULE3]
        (mode == UAC_MODE_ADDSUB && !sub_sel && ({1'b0, addend_a} + {1'b0, addend_b}) <= MAXV)
        |=> result == $past(addend_a) + $past(addend_b))
        else $error("add result wrong");

    a_sub_clamp: assert property (@(posedge core_clk) disable iff (rst) // [RULE7]
        (mode == UAC_MODE_ADDSUB && sub_sel && addend_a < addend_b) |=> result == '0)
        else $error("negative difference not clamped");

    a_add_sat: assert property (@(posedge core_clk) disable iff (rst) // [RULE6]
        (mode == UAC_MODE_ADDSUB && !sub_sel && ({1'b0, addend_a} + {1'b0, addend_b}) > MAXV)
        |=> result == MAXV)
        else $error("sum not saturated");

    a_mul_shift: assert property (@(posedge core_clk) disable iff (rst) // [RULE2]
        (mode == UAC_MODE_MUL && ((32'(scale_k) * 32'(mcand_x)) >> shift_amt) <= 32'(MAXV))
        |=> result == 16'((32'($past(scale_k)) * 32'($past(mcand_x))) >> $past(shift_amt)))
        else $error("shifted product wrong");

    a_mul_sat: assert property (@(posedge core_clk) disable iff (rst) // [RULE6]
        (mode == UAC_MODE_MUL && ((32'(scale_k) * 32'(mcand_x)) >> shift_amt) > MAXV)
        |=> result == MAXV)
        else $error("product not saturated");

    a_halve_one: assert property (@(posedge core_clk) disable iff (rst) // [RULE8]
        (mode == UAC_MODE_MUL && scale_k == 16'h0001 && shift_amt == 5'h01)
        |=> result == ($past(mcand_x) >> 1))
        else $error("shift by one does not halve");

    a_muladd_route: assert property (@(posedge core_clk) disable iff (rst) // [RULE4]
        (mode == UAC_MODE_MUL_ADD && !sub_sel && shift_amt == '0 && scale_k == 16'h0001
         && ({1'b0, mcand_x} + {1'b0, addend_b}) <= MAXV)
        |=> result == $past(mcand_x) + $past(addend_b))
        else $error("product not routed into addend");

    a_addmul_route: assert property (@(posedge core_clk) disable iff (rst) // [RULE5]
        (mode == UAC_MODE_ADD_MUL && sub_sel && shift_amt == '0 && scale_k == 16'h0001)
        |=> result == (($past(addend_a) < $past(addend_b)) ? 16'h0000
                       : $past(addend_a) - $past(addend_b)))
        else $error("difference not routed into multiplicand");

    a_mode_mul: assert property (@(posedge core_clk) disable iff (rst) // [RULE1]
        (mode == UAC_MODE_MUL && scale_k == '0) |=> result == '0)
        else $error("multiply mode ignores scale");

    a_sub_result: assert property (@(posedge core_clk) disable iff (rst) // [RULE3]
        (mode == UAC_MODE_ADDSUB && sub_sel && addend_a >= addend_b)
        |=> result == $past(addend_a) - $past(addend_b))
        else $error("difference wrong");

    a_shift_div: assert property (@(posedge core_clk) disable iff (rst) // [RULE8]
        (mode == UAC_MODE_MUL && scale_k == 16'h0001)
        |=> result == ($past(mcand_x) >> $past(shift_amt)))
        else $error("shift does not divide by a power of two");

    a_muladd_result: assert property (@(posedge core_clk) disable iff (rst) // [RULE4]
        (mode == UAC_MODE_MUL_ADD && !sub_sel
         && (((32'(scale_k) * 32'(mcand_x)) >> shift_amt) + 32'(addend_b)) <= 32'(MAXV))
        |=> result == 16'((32'($past(scale_k)) * 32'($past(mcand_x))) >> $past(shift_amt))
                      + $past(addend_b))
        else $error("shifted product plus addend wrong");

    a_muladd_clamp: assert property (@(posedge core_clk) disable iff (rst) // [RULE7]
        (mode == UAC_MODE_MUL_ADD && sub_sel
         && ((32'(scale_k) * 32'(mcand_x)) >> shift_amt) < 32'(addend_b))
        |=> result == '0)
        else $error("negative chained difference not clamped");

    a_muladd_sat: assert property (@(posedge core_clk) disable iff (rst) // [RULE6]
        (mode == UAC_MODE_MUL_ADD && sub_sel
         && ((32'(scale_k) * 32'(mcand_x)) >> shift_amt) > 32'(MAXV))
        |=> result == MAXV - $past(addend_b))
        else $error("saturated product not used as first addend");

    a_addmul_sat: assert property (@(posedge core_clk) disable iff (rst) // [RULE6]
        (mode == UAC_MODE_ADD_MUL && !sub_sel
         && (32'(addend_a) + 32'(addend_b)) <= 32'(MAXV)
         && (((32'(addend_a) + 32'(addend_b)) * 32'(scale_k)) >> shift_amt) > 32'(MAXV))
        |=> result == MAXV)
        else $error("chained product not saturated");

    a_addmul_clamp: assert property (@(posedge core_clk) disable iff (rst) // [RULE7]
        (mode == UAC_MODE_ADD_MUL && sub_sel && addend_a < addend_b) |=> result == '0)
        else $error("clamped difference not zero after multiply");

    // Main scenarios: each mode, a clamped difference and a restart on
    // any release of reset, the first one included
    c_mul:    cover property (@(posedge core_clk) mode == UAC_MODE_MUL && shift_amt != '0);
    c_sub0:   cover property (@(posedge core_clk) mode == UAC_MODE_ADDSUB && sub_sel
                              && addend_a < addend_b);
    c_muladd: cover property (@(posedge core_clk) mode == UAC_MODE_MUL_ADD);
    c_addmul: cover property (@(posedge core_clk) mode == UAC_MODE_ADD_MUL && sub_sel);
    c_restart: cover property (@(posedge core_clk) $fell(rst));

endmodule : uac_arith_core

// >>> verif/uac_opnd_buf.sv
`timescale 1ns/10ps
// ----------------------------------------
// Operand buffer feeding the core
// ----------------------------------------
// Holds the last captured set, as a neighbouring data buffer would
module uac_opnd_buf (
    input  wire logic        core_clk, // System clock
    input  wire logic        ld,       // Capture a new operand set
    input  wire logic [63:0] opnds,    // Packed K, X, A, B
    output logic      [15:0] scale_k,  // Scale operand
    output logic      [15:0] mcand_x,  // Multiplicand operand
    output logic      [15:0] addend_a, // First addend
    output logic      [15:0] addend_b  // Second addend
);
    always_ff @(posedge core_clk) begin
        if (ld) begin
            {scale_k, mcand_x, addend_a, addend_b} <= opnds;
        end
    end
endmodule : uac_opnd_buf

// >>> verif/tb_top.sv
`timescale 1ns/10ps
module tb_top
    import uac_pkg::*;
;
    logic        core_clk = 1'b0;
    logic        rst = 1'b1;
    logic        ld = 1'b0;
    logic        sub_sel = 1'b0;
    logic [4:0]  shift_amt = 5'h00;
    logic [63:0] opnds = 64'h0;
    uac_mode_t   mode = UAC_MODE_MUL;
    logic [15:0] k, x, a, b, result;
    int          num_errors = 0;
    int          n_checks = 0;
    always #5 core_clk = ~core_clk;
    uac_opnd_buf i_uac_opnd_buf (.core_clk(core_clk), .ld(ld), .opnds(opnds),
        .scale_k(k), .mcand_x(x), .addend_a(a), .addend_b(b));
    uac_arith_core i_uac_arith_core (.core_clk(core_clk), .rst(rst), .mode(mode),
        .sub_sel(sub_sel), .shift_amt(shift_amt), .scale_k(k), .mcand_x(x),
        .addend_a(a), .addend_b(b), .result(result));
    task automatic check(input logic [15:0] exp);
        n_checks++;
        if (result !== exp) begin
            num_errors++;
            $display("unexpected at %0t: result %h, want %h", $time, result, exp);
        end
    endtask : check
    // Operands take one edge through the buffer, then one edge in the core
    task automatic run(input uac_mode_t m, input logic s, input logic [4:0] n,
                       input logic [63:0] o, input logic [15:0] exp);
        @(posedge core_clk);
        mode <= m;
        sub_sel <= s;
        shift_amt <= n;
        opnds <= o;
        ld <= 1'b1;
        @(posedge core_clk);
        ld <= 1'b0;
        @(posedge core_clk);
        @(negedge core_clk);
        check(exp);
    endtask : run
    task automatic test_mul;
        run(UAC_MODE_MUL, 1'b0, 5'h00, 64'h0003_0005_0000_0000, 16'h000F);
        run(UAC_MODE_MUL, 1'b0, 5'h01, 64'h0001_00F0_0000_0000, 16'h0078);
        run(UAC_MODE_MUL, 1'b0, 5'h00, 64'h0000_1234_0000_0000, 16'h0000);
        run(UAC_MODE_MUL, 1'b0, 5'h00, 64'hFFFF_FFFF_0000_0000, 16'hFFFF);
        run(UAC_MODE_MUL, 1'b0, 5'h10, 64'hFFFF_FFFF_0000_0000, 16'hFFFE);
        run(UAC_MODE_MUL, 1'b0, 5'h1F, 64'hFFFF_FFFF_0000_0000, 16'h0001);
    endtask : test_mul
    task automatic test_addsub;
        run(UAC_MODE_ADDSUB, 1'b0, 5'h03, 64'h0000_0000_0003_0004, 16'h0007);
        run(UAC_MODE_ADDSUB, 1'b0, 5'h00, 64'h0000_0000_FFFF_0001, 16'hFFFF);
        run(UAC_MODE_ADDSUB, 1'b1, 5'h00, 64'h0000_0000_0009_0004, 16'h0005);
        run(UAC_MODE_ADDSUB, 1'b1, 5'h00, 64'h0000_0000_0003_0004, 16'h0000);
    endtask : test_addsub
    task automatic test_chain;
        run(UAC_MODE_MUL_ADD, 1'b0, 5'h00, 64'h0003_000A_0000_0064, 16'h0082);
        run(UAC_MODE_MUL_ADD, 1'b1, 5'h00, 64'h0003_000A_0000_001E, 16'h0000);
        run(UAC_MODE_MUL_ADD, 1'b1, 5'h00, 64'h0003_000A_0000_001F, 16'h0000);
        run(UAC_MODE_MUL_ADD, 1'b1, 5'h00, 64'hFFFF_FFFF_0000_0001, 16'hFFFE);
        run(UAC_MODE_ADD_MUL, 1'b1, 5'h01, 64'h0004_0000_0005_0003, 16'h0004);
        run(UAC_MODE_MUL_ADD, 1'b0, 5'h00, 64'h0001_1234_0000_0100, 16'h1334);
        run(UAC_MODE_ADD_MUL, 1'b1, 5'h00, 64'h0001_0000_0009_0004, 16'h0005);
        run(UAC_MODE_ADD_MUL, 1'b1, 5'h01, 64'h0004_0000_0003_0005, 16'h0000);
        run(UAC_MODE_ADD_MUL, 1'b0, 5'h00, 64'h03E8_0000_0064_0064, 16'hFFFF);
    endtask : test_chain
    task automatic test_reset;
        @(posedge core_clk);
        rst <= 1'b1;
        @(posedge core_clk);
        rst <= 1'b0;
        @(negedge core_clk);
        check(16'h0000);
        // The last chain operands still stand, so the first free edge reloads them
        @(negedge core_clk);
        check(16'hFFFF);
    endtask : test_reset
    task automatic print_verdict;
        $display("checks %0d, errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : print_verdict
    initial begin
        repeat (12) @(posedge core_clk);
        rst <= 1'b0;
        @(negedge core_clk);
        check(16'h0000);
        test_mul();
        test_addsub();
        test_chain();
        test_reset();
        print_verdict();
    end
    initial begin
        #200000;
        num_errors++;
        $display("unexpected at %0t: watchdog expired", $time);
        print_verdict();
    end
endmodule : tb_top
